// File: verilog/ptp_cmd_pkg.sv
package ptp_cmd_pkg;

  // Word indices of the registers; byte address is four times the index.
  localparam logic [9:0] IDX_PAGE_SEL = 10'h013;
  localparam logic [9:0] IDX_CMD = 10'h014;
  localparam logic [9:0] IDX_TDR = 10'h015;
  localparam logic [9:0] IDX_TRIG_STS = 10'h017;

  // Page select value that maps the timing registers.
  localparam logic [2:0] PAGE_PTP = 3'h4;
  localparam logic [2:0] PAGE_RESET = 3'h0;

  // Command register field positions.
  localparam int TRIG_IDX_LSB = 10;
  localparam int BIT_DIS = 9;
  localparam int BIT_EN = 8;
  localparam int BIT_READ = 7;
  localparam int BIT_LOAD = 6;
  localparam int BIT_CLK = 5;

  // Trigger array and time-data sequencing.
  localparam int NUM_TRIG = 8;
  localparam int FIELD_COUNT = 4;
  localparam logic [2:0] TRIG_FIELDS = 3'h4;
  localparam logic [2:0] LAST_FIELD = 3'h3;
  localparam logic [2:0] CLK_PIECES = 3'h4;
  localparam logic [2:0] CNT_RESET = 3'h0;
  localparam logic [2:0] IDX_RESET = 3'h0;
  localparam logic [15:0] FIELD_RESET = 16'h0000;
  localparam logic [63:0] TIME_RESET = 64'h0000_0000_0000_0000;
  localparam logic [7:0] STS_RESET = 8'h00;

  // Time-data port sequencing modes.
  typedef enum logic [3:0] {
    MODE_IDLE = 4'b0001,
    MODE_LOAD = 4'b0010,
    MODE_RTRIG = 4'b0100,
    MODE_RCLK = 4'b1000
  } tdr_mode_t;

endpackage

// File: verilog/reg_access_if.sv
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
  logic req;
  logic write;
  logic [9:0] word;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic err;

  modport port (output req, output write, output word, output wdata,
                input rdata, input err);
  modport core (input req, input write, input word, input wdata,
                output rdata, output err);
endinterface
`default_nettype wire

// File: verilog/apb_reg_port.sv
`timescale 1ns/10ps
`default_nettype none
module apb_reg_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready_q,
  output logic [31:0] prdata_q,
  output logic pslverr_q,
  // Register core
  reg_access_if.port bus
);

  logic access;
  logic aligned;

  // One wait state: the core acts in the first access cycle, and the
  // answer is registered so that every APB output comes from a flop.
  assign access = psel & penable & ~pready_q;
  assign aligned = (paddr[1:0] == 2'h0);
  assign bus.req = access & aligned;
  assign bus.write = pwrite;
  assign bus.word = paddr[11:2];
  assign bus.wdata = pwdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access;
      pslverr_q <= access & (~aligned | bus.err);
      prdata_q <= (access & ~pwrite & aligned & ~bus.err) ?
                  bus.rdata : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// File: verilog/ptp_trigger_clock_control.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Timing registers respond only while page select holds value four.
// - Command register at index 0x14; top three bits ignored, read zero.
// - Three-bit trigger index, reset zero, picks the commanded trigger.
// - Disable bit 9 disables indexed trigger; self-clears, reads zero.
// - Command bits never show trigger state; separate status register does.
// - Disabled trigger keeps driving its current level onto assigned pin.
// - Enable bit 8 enables indexed trigger; self-clears, reads zero.
// - Readback bit 7 makes time-data reads return fields in load order.
// - Load bit 6 disables trigger at once; data writes fill its fields.
// - Load ends after last field written or on enable, whichever first.
// - Load bit reads one during a load, clears when load completes.
// - Clock sample bit 5 captures protocol time for readout; reads zero.
// - Time-data port at 0x15 moves 16-bit pieces; past the end reads zero.
module ptp_trigger_clock_control
  import ptp_cmd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Timing engine, same clock
  input wire logic [63:0] ptp_time,
  input wire logic [NUM_TRIG-1:0] trig_fire,
  // Trigger pins
  output logic [NUM_TRIG-1:0] trig_pin_out,
  output logic [NUM_TRIG-1:0] trig_pin_oe
);

  reg_access_if bus ();

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  apb_reg_port u_port (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready_q(pready),
    .prdata_q(prdata),
    .pslverr_q(pslverr),
    .bus(bus)
  );

  logic [2:0] page_q;
  logic [2:0] idx_q;
  logic [2:0] act_idx_q;
  tdr_mode_t mode_q;
  tdr_mode_t mode_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [NUM_TRIG-1:0] sts_q;
  logic [NUM_TRIG-1:0] sts_d;
  logic [63:0] sample_q;
  logic [15:0] cfg_q [NUM_TRIG][FIELD_COUNT];
  logic [NUM_TRIG-1:0] pin_level_q;
  logic [NUM_TRIG-1:0] pin_oe_q;

  logic page_ok;
  logic hit_page;
  logic hit_cmd;
  logic hit_tdr;
  logic hit_sts;
  logic wr;
  logic rd;
  logic cmd_wr;
  logic [2:0] new_idx;
  logic do_dis;
  logic do_en;
  logic do_read;
  logic do_load;
  logic do_clk;
  logic tdr_wr;
  logic tdr_rd;
  logic load_busy;
  logic load_last;
  logic [15:0] cmd_rdata;
  logic [15:0] trig_piece;
  logic [15:0] clk_piece;
  logic [15:0] tdr_rdata;

  // Address decode and command strobes.
  assign page_ok = (page_q == PAGE_PTP);
  assign hit_page = (bus.word == IDX_PAGE_SEL);
  assign hit_cmd = page_ok & (bus.word == IDX_CMD);
  assign hit_tdr = page_ok & (bus.word == IDX_TDR);
  assign hit_sts = page_ok & (bus.word == IDX_TRIG_STS);
  assign bus.err = ~(hit_page | hit_cmd | hit_tdr | hit_sts);
  assign wr = bus.req & bus.write;
  assign rd = bus.req & ~bus.write;
  assign cmd_wr = wr & hit_cmd;
  assign new_idx = bus.wdata[TRIG_IDX_LSB +: 3];
  assign do_dis = cmd_wr & bus.wdata[BIT_DIS];
  assign do_en = cmd_wr & bus.wdata[BIT_EN];
  assign do_read = cmd_wr & bus.wdata[BIT_READ];
  assign do_load = cmd_wr & bus.wdata[BIT_LOAD];
  assign do_clk = cmd_wr & bus.wdata[BIT_CLK];
  assign tdr_wr = wr & hit_tdr;
  assign tdr_rd = rd & hit_tdr;
  assign load_busy = (mode_q == MODE_LOAD);
  assign load_last = tdr_wr & load_busy & (cnt_q == LAST_FIELD);

  // Self-clearing command bits and reserved bits always read zero.
  assign cmd_rdata = {3'h0, idx_q, 3'h0, load_busy, 6'h00};

  // Pieces beyond the last available one read as zero.
  assign trig_piece = (cnt_q < TRIG_FIELDS) ?
                      cfg_q[act_idx_q][cnt_q[1:0]] : FIELD_RESET;
  assign clk_piece = (cnt_q < CLK_PIECES) ?
                     sample_q[{cnt_q[1:0], 4'h0} +: 16] : FIELD_RESET;
  assign tdr_rdata = (mode_q == MODE_RTRIG) ? trig_piece :
                     (mode_q == MODE_RCLK) ? clk_piece : FIELD_RESET;

  assign bus.rdata = hit_page ? {29'h0000_0000, page_q} :
                     hit_cmd ? {16'h0000, cmd_rdata} :
                     hit_tdr ? {16'h0000, tdr_tdata_fix(tdr_rdata)} :
                     hit_sts ? {24'h00_0000, sts_q} : 32'h0000_0000;

  function automatic logic [15:0] tdr_tdata_fix(input logic [15:0] v);
    tdr_tdata_fix = v;
  endfunction

  // Piece sequencer: a new load, readback or clock command restarts it at the first piece.
  always_comb begin
    mode_d = mode_q;
    cnt_d = cnt_q;
    if (do_load) begin
      mode_d = MODE_LOAD;
      cnt_d = CNT_RESET;
    end else if (do_read) begin
      mode_d = MODE_RTRIG;
      cnt_d = CNT_RESET;
    end else if (do_clk) begin
      mode_d = MODE_RCLK;
      cnt_d = CNT_RESET;
    end else begin
      case (mode_q)
        MODE_LOAD: begin
          if (tdr_wr) begin
            cnt_d = cnt_q + 3'h1;
            if (load_last) begin
              mode_d = MODE_IDLE;
            end
          end
        end
        MODE_RTRIG: begin
          if (tdr_rd && (cnt_q < TRIG_FIELDS)) begin
            cnt_d = cnt_q + 3'h1;
          end
        end
        MODE_RCLK: begin
          if (tdr_rd && (cnt_q < CLK_PIECES)) begin
            cnt_d = cnt_q + 3'h1;
          end
        end
        MODE_IDLE: begin
          cnt_d = cnt_q;
        end
        default: begin
          mode_d = MODE_IDLE;
          cnt_d = CNT_RESET;
        end
      endcase
    end
    // An enable ends a load in progress, even one started by this write.
    if (do_en && (mode_d == MODE_LOAD)) begin
      mode_d = MODE_IDLE;
    end
  end

  // Trigger state; enable is applied last so it wins in a combined write.
  always_comb begin
    sts_d = sts_q;
    if (do_dis) begin
      sts_d[new_idx] = 1'b0;
    end
    if (do_load) begin
      sts_d[new_idx] = 1'b0;
    end
    if (do_en) begin
      sts_d[new_idx] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= PAGE_RESET;
      idx_q <= IDX_RESET;
      act_idx_q <= IDX_RESET;
      mode_q <= MODE_IDLE;
      cnt_q <= CNT_RESET;
      sts_q <= STS_RESET;
    end else begin
      if (wr && hit_page) begin
        page_q <= bus.wdata[2:0];
      end
      if (cmd_wr) begin
        idx_q <= new_idx;
      end
      if (do_load || do_read) begin
        act_idx_q <= new_idx;
      end
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      sts_q <= sts_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_q <= TIME_RESET;
    end else if (do_clk) begin
      sample_q <= ptp_time;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < NUM_TRIG; t++) begin
        for (int f = 0; f < FIELD_COUNT; f++) begin
          cfg_q[t][f] <= FIELD_RESET;
        end
      end
    end else if (tdr_wr && load_busy) begin
      cfg_q[act_idx_q][cnt_q[1:0]] <= bus.wdata[15:0];
    end
  end

  // A disabled trigger freezes its level but keeps the pin driven, so a
  // disable never leaves the pin floating.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_q <= STS_RESET;
      pin_oe_q <= STS_RESET;
    end else begin
      for (int t = 0; t < NUM_TRIG; t++) begin
        if (sts_q[t]) begin
          pin_level_q[t] <= trig_fire[t];
        end
        pin_oe_q[t] <= cfg_q[t][0][0];
      end
    end
  end

  assign trig_pin_out = pin_level_q;
  assign trig_pin_oe = pin_oe_q;

  property p_page_gate;
    bus.req && (page_q != PAGE_PTP) && (bus.word == IDX_CMD) |=> pslverr;
  endproperty
  a_page_gate: assert property (p_page_gate) else $error("page gate");

  property p_cmd_zero_bits;
    hit_cmd |-> (bus.rdata[31:13] == 19'h0) && (bus.rdata[9:7] == 3'h0) &&
                (bus.rdata[5:0] == 6'h00);
  endproperty
  a_cmd_zero_bits: assert property (p_cmd_zero_bits)
    else $error("command bits not zero");

  property p_index_store;
    cmd_wr |=> idx_q == $past(new_idx);
  endproperty
  a_index_store: assert property (p_index_store) else $error("index");

  property p_disable;
    do_dis && !do_en |=> !sts_q[$past(new_idx)];
  endproperty
  a_disable: assert property (p_disable) else $error("disable");

  property p_enable;
    do_en |=> sts_q[$past(new_idx)];
  endproperty
  a_enable: assert property (p_enable) else $error("enable");

  property p_pin_kept;
    do_dis |=> ##1 (pin_oe_q == $past(pin_oe_q, 2));
  endproperty
  a_pin_kept: assert property (p_pin_kept) else $error("pin released");

  property p_load_start;
    do_load && !do_en |=> load_busy && (cnt_q == 3'h0) &&
                          !sts_q[$past(new_idx)];
  endproperty
  a_load_start: assert property (p_load_start) else $error("load");

  property p_load_hold;
    load_busy && !load_last && !do_en && !do_read && !do_clk |=> load_busy;
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("load ended");

  property p_load_end;
    load_last && !cmd_wr ##1 1'b1 |-> !load_busy ##1 1'b1;
  endproperty
  a_load_end: assert property (p_load_end) else $error("load stuck");

  property p_sample;
    do_clk |=> (sample_q == $past(ptp_time)) && (mode_q == MODE_RCLK) &&
               (cnt_q == 3'h0);
  endproperty
  a_sample: assert property (p_sample) else $error("sample");

  property p_past_end;
    hit_tdr && (mode_q == MODE_RCLK) && (cnt_q >= CLK_PIECES) |->
      bus.rdata == 32'h0000_0000;
  endproperty
  a_past_end: assert property (p_past_end) else $error("past end");

  property p_enable_ends_load;
    do_en |=> !load_busy;
  endproperty
  a_enable_ends_load: assert property (p_enable_ends_load)
    else $error("enable left load running");

  property p_piece_restart;
    do_load || do_read || do_clk |=> (cnt_q == CNT_RESET);
  endproperty
  a_piece_restart: assert property (p_piece_restart)
    else $error("piece sequence not restarted");

  property p_read_advance;
    tdr_rd && (mode_q == MODE_RTRIG) && (cnt_q < TRIG_FIELDS) |=>
      (cnt_q == $past(cnt_q) + 3'h1);
  endproperty
  a_read_advance: assert property (p_read_advance)
    else $error("readback did not advance");

  property p_command_index;
    do_load || do_read |=> (act_idx_q == $past(new_idx));
  endproperty
  a_command_index: assert property (p_command_index)
    else $error("command used stale index");

endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module tb;
  import ptp_cmd_pkg::*;
  localparam logic [11:0] A_PAGE = {IDX_PAGE_SEL, 2'b00};
  localparam logic [11:0] A_CMD = {IDX_CMD, 2'b00};
  localparam logic [11:0] A_TDR = {IDX_TDR, 2'b00};
  localparam logic [11:0] A_STS = {IDX_TRIG_STS, 2'b00};
  localparam logic [32:0] ERR = {1'b1, 32'h0000_0000};
  // Clock and reset
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  // APB master side
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  // Timing engine and pins
  logic [63:0] ptp_time = 64'h0000_0000_0000_0000;
  logic [NUM_TRIG-1:0] trig_fire = 8'h00;
  logic [NUM_TRIG-1:0] trig_pin_out;
  logic [NUM_TRIG-1:0] trig_pin_oe;
  // Bench state
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_0011;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [15:0] f[4];

  ptp_trigger_clock_control dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ptp_time(ptp_time),
    .trig_fire(trig_fire), .trig_pin_out(trig_pin_out),
    .trig_pin_oe(trig_pin_oe)
  );

  always #2 pclk = ~pclk;

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  function automatic logic [31:0] cmd(input logic [2:0] i,
                                      input logic [15:0] b);
    return {16'h0000, b | (16'(i) << TRIG_IDX_LSB)};
  endfunction

  // The expectation is queued before the request, so the monitor never
  // sees an answer ahead of its note.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed wait: only the bench timeout may end a stalled transfer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0_0000_0000);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] d);
    xfer(1'b0, a, 32'h0000_0000, {17'h0_0000, d});
  endtask

  task automatic complete_run();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
                 {pslverr, prdata}, 33'h0_0000_0000);
      end else begin
        e = exp_q.pop_front();
        `CHK({pslverr, prdata}, e)
      end
    end
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, A_CMD, 32'h0000_0000, ERR);
    wr(A_PAGE, 32'h0000_0004);
    rd(A_PAGE, 16'h0004);
    rd(A_CMD, 16'h0000);
    wr(A_CMD, 32'h0000_EC00);
    rd(A_CMD, 16'h0C00);
    xfer(1'b0, 12'h060, 32'h0000_0000, ERR);
    xfer(1'b0, A_CMD | 12'h002, 32'h0000_0000, ERR);
    // Load trigger 5; field 0 bit 0 assigns it to its pin.
    wr(A_CMD, cmd(3'h5, 16'h0040));
    rd(A_CMD, 16'(cmd(3'h5, 16'h0040)));
    for (int i = 0; i < 4; i++) begin
      f[i] = rnd() | ((i == 0) ? 16'h0001 : 16'h0000);
      wr(A_TDR, {rnd(), f[i]});
      rd(A_CMD, 16'(cmd(3'h5, (i < 3) ? 16'h0040 : 16'h0000)));
    end
    `CHK(trig_pin_oe[5], 1'b1)
    wr(A_CMD, cmd(3'h5, 16'h0080));
    rd(A_CMD, 16'(cmd(3'h5, 16'h0000)));
    for (int i = 0; i < 5; i++) begin
      rd(A_TDR, (i < 4) ? f[i] : 16'h0000);
    end
    wr(A_CMD, cmd(3'h5, 16'h0100));
    rd(A_CMD, 16'(cmd(3'h5, 16'h0000)));
    rd(A_STS, 16'h0020);
    trig_fire <= 8'h20;
    repeat (3) @(posedge pclk);
    `CHK(trig_pin_out[5], 1'b1)
    wr(A_CMD, cmd(3'h2, 16'h0100));
    rd(A_STS, 16'h0024);
    wr(A_CMD, cmd(3'h5, 16'h0200));
    rd(A_STS, 16'h0004);
    trig_fire <= 8'h00;
    repeat (3) @(posedge pclk);
    `CHK({trig_pin_oe[5], trig_pin_out[5]}, 2'b11)
    // A load cut short by the enable bit.
    wr(A_CMD, cmd(3'h2, 16'h0040));
    rd(A_STS, 16'h0000);
    wr(A_TDR, 32'h0000_0000);
    wr(A_CMD, cmd(3'h2, 16'h0100));
    rd(A_CMD, 16'(cmd(3'h2, 16'h0000)));
    rd(A_STS, 16'h0004);
    ptp_time <= {rnd(), rnd(), rnd(), rnd()};
    wr(A_CMD, cmd(3'h2, 16'h0020));
    rd(A_CMD, 16'(cmd(3'h2, 16'h0000)));
    for (int i = 0; i < 5; i++) begin
      rd(A_TDR, (i < 4) ? ptp_time[16*i+:16] : 16'h0000);
    end
    wr(A_CMD, cmd(3'h2, 16'h0020));
    rd(A_TDR, ptp_time[15:0]);
    wr(A_CMD, cmd(3'h2, 16'h0020));
    rd(A_TDR, ptp_time[15:0]);
    wr(A_PAGE, 32'h0000_0000);
    xfer(1'b1, A_TDR, 32'h0000_0000, ERR);
    repeat (3) @(posedge pclk);
    complete_run();
  end
endmodule
`default_nettype wire
